/* File: hw/clk_div_cfg.svh */
/*
 Constants of the system clock divide control: field codes, reset values,
 warm-up timing and memory cycle lengths.
 Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef CLK_DIV_CFG_SVH
`define CLK_DIV_CFG_SVH

// ----------------------------------------
// Divide select codes
// ----------------------------------------
`define CDS_MULT 2'h0
`define CDS_RSVD 2'h1
`define CDS_DIV1 2'h2
`define CDS_DIV1024 2'h3
`define CDS_RESET 2'h2

// ----------------------------------------
// Divider and warm-up counts
// ----------------------------------------
`define DIV_SLOW_COUNT 1024
`define WARMUP_OSC_CYCLES 65536

// ----------------------------------------
// Memory cycle lengths in system clocks
// ----------------------------------------
`define MEMCYC_INT 1
`define MEMCYC_BUS1 1
`define MEMCYC_BUS2 2
`define MEMCYC_BUS4 4

`endif

/* File: hw/clk_div_pkg.sv */
/*
 Types of the system clock divide control.
 Assumes the constants header is on the include path.
*/
package clk_div_pkg;
`include "clk_div_cfg.svh"

   typedef enum logic [1:0] {
      bus_one,
      bus_two,
      bus_four
   } ext_bus_t;

   typedef enum logic [1:0] {
      mult_off,
      mult_warm,
      mult_ready
   } mult_state_t;

   function automatic logic [2:0] memcyc_len(input logic ext_code, input ext_bus_t bus);
      if (!ext_code) begin
         memcyc_len = 3'(`MEMCYC_INT);
      end else begin
         case (bus)
            bus_one: memcyc_len = 3'(`MEMCYC_BUS1);
            bus_two: memcyc_len = 3'(`MEMCYC_BUS2);
            default: memcyc_len = 3'(`MEMCYC_BUS4);
         endcase
      end
   endfunction
endpackage

/* File: hw/warmup_timer.sv */
/*
 Crystal multiplier warm-up timer counted on oscillator edges.
 Assumes osc_tick is a one-cycle enable per external oscillator cycle.
*/
`timescale 1ns/100ps
`include "clk_div_cfg.svh"
module warmup_timer
   import clk_div_pkg::*;
#(
   parameter int WARMUP_CYCLES = `WARMUP_OSC_CYCLES
) (
   input wire logic clk_sys, // System clock
   input wire logic rst, // Sync reset, high
   input wire logic run, // Multiplier enabled
   input wire logic osc_tick, // Oscillator cycle enable
   output logic done // Warm-up complete
);
   typedef struct packed {
      logic [16:0] count;
      logic done;
   } warm_t;

   warm_t state;
   warm_t next_state;

   always_comb begin
      next_state = state;
      if (!run) begin
         next_state.count = '0;
         next_state.done = 1'b0;
      end else if (osc_tick && !state.done) begin
         next_state.count = state.count + 17'h00001;
         if (state.count == 17'(WARMUP_CYCLES - 1)) begin
            next_state.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign done = state.done;
endmodule

/* File: hw/memcyc_timer.sv */
/*
 Memory cycle timer: marks the start of each memory cycle in system clocks.
 Assumes sys_en is the system clock enable pulse.
*/
`timescale 1ns/100ps
module memcyc_timer
   import clk_div_pkg::*;
(
   input wire logic clk_sys, // System clock
   input wire logic rst, // Sync reset, high
   input wire logic sys_en, // System clock enable
   input wire logic ext_code, // Executing external code
   input wire ext_bus_t bus_mode, // External bus structure
   output logic memcyc_start // First system clock of a memory cycle
);
   typedef struct packed {
      logic [2:0] phase;
   } mc_t;

   mc_t state;
   mc_t next_state;
   logic [2:0] len;

   always_comb begin
      len = memcyc_len(ext_code, bus_mode);
      next_state = state;
      if (sys_en) begin
         if (state.phase >= len - 3'h1) begin
            next_state.phase = 3'h0;
         end else begin
            next_state.phase = state.phase + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign memcyc_start = sys_en && (state.phase == 3'h0);
endmodule

/* File: hw/system_clock_divide_control.sv */
/*
 System clock divide control: divide select, crystal multiplier enable and
 warm-up, ready flag, write restrictions, automatic switchback and memory
 cycle timing. The system clock appears as a one-cycle enable on clk_sys.
 Assumes clk_sys runs at four times the external oscillator (40 MHz vs
 10 MHz), so the 4X multiplier output equals clk_sys itself.
*/
`timescale 1ns/100ps
`include "clk_div_cfg.svh"
// How it works
// - Two-bit select picks multiply, divide by 1 (reset) or divide by 1024.
// - Factor bit writable only in divide-by-1 with multiplier disabled.
// - Setting multiplier enable starts warm-up in the chosen factor.
// - Multiplier enable writable only in divide-by-1 with ring flag zero.
// - During warm-up ready stays low and writes of 00b are blocked.
// - Ready flag rises when warm-up completes.
// - Warm-up lasts about 65536 oscillator cycles.
// - Multiplier output takes over at the next memory cycle after 00b.
// - Divide-by-1024 with switchback enabled returns to divide by 1 on events.
// - Switchback acts only in divide-by-1024; other settings unaffected.
// - Internal code memory cycle is one system clock.
// - External code memory cycle is 1, 2 or 4 system clocks.
// - Selected system clock enable drives timers and serial baud logic.
module system_clock_divide_control
   import clk_div_pkg::*;
#(
   parameter int OSC_RATIO = 4,
   parameter int WARMUP_CYCLES = `WARMUP_OSC_CYCLES,
   parameter int SLOW_COUNT = `DIV_SLOW_COUNT
) (
   input wire logic clk_sys, // 40 MHz base clock
   input wire logic rst, // Sync reset, high
   input wire logic divide_wr, // Write strobe for divide select
   input wire logic [1:0] divide_wdata, // New divide select
   input wire logic enable_wr, // Write strobe for multiplier enable
   input wire logic enable_wdata, // New multiplier enable
   input wire logic factor_wr, // Write strobe for factor select
   input wire logic factor_wdata, // New factor: 1 = 4X, 0 = 2X
   input wire logic switchback_wr, // Write strobe for switchback enable
   input wire logic switchback_wdata, // New switchback enable
   input wire logic ring_osc_mode_flag, // Ring oscillator active
   input wire logic ext_irq_event, // Enabled external interrupt, pulse
   input wire logic serial_start_pin, // Serial receive line, async
   input wire logic ext_code, // Executing external program code
   input wire ext_bus_t bus_mode, // External bus structure
   output logic [1:0] clock_divide_select, // Divide select field
   output logic multiplier_enable, // Multiplier enable bit
   output logic multiply_factor_select, // Factor select bit
   output logic auto_switchback_enable, // Switchback enable bit
   output logic multiplier_ready_flag, // Multiplier ready flag
   output logic sys_clk_en, // System clock enable pulse
   output logic memcyc_start // First clock of a memory cycle
);
   typedef struct packed {
      logic [1:0] cds;
      logic [1:0] pend_cds;
      logic pend;
      logic mul_en;
      logic factor;
      logic back_en;
      mult_state_t mstate;
      logic [1:0] osc_div;
      logic [9:0] slow_div;
      logic toggle2x;
      logic rx_s1;
      logic rx_s2;
      logic rx_prev;
      logic sys_en;
   } ctl_t;

   ctl_t state;
   ctl_t next_state;
   logic osc_tick;
   logic warm_done;
   logic rx_start;
   logic mc_start;

   // ----------------------------------------
   // Oscillator tick, one clk_sys in OSC_RATIO
   // ----------------------------------------
   assign osc_tick = (state.osc_div == 2'(OSC_RATIO - 1));

   warmup_timer #(
      .WARMUP_CYCLES(WARMUP_CYCLES)
   ) u_warm (
      .clk_sys(clk_sys),
      .rst(rst),
      .run(state.mul_en),
      .osc_tick(osc_tick),
      .done(warm_done)
   );

   memcyc_timer u_memcyc (
      .clk_sys(clk_sys),
      .rst(rst),
      .sys_en(state.sys_en),
      .ext_code(ext_code),
      .bus_mode(bus_mode),
      .memcyc_start(mc_start)
   );

   // Falling edge of the synchronised receive line
   assign rx_start = state.rx_prev && !state.rx_s2;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_state.rx_s1 = serial_start_pin;
      next_state.rx_s2 = state.rx_s1;
      next_state.rx_prev = state.rx_s2;
      next_state.osc_div = osc_tick ? 2'h0 : state.osc_div + 2'h1;

      if (factor_wr && state.cds == `CDS_DIV1 && !state.mul_en) begin
         next_state.factor = factor_wdata;
      end

      if (enable_wr && state.cds == `CDS_DIV1 && !ring_osc_mode_flag) begin
         next_state.mul_en = enable_wdata;
      end

      if (switchback_wr) begin
         next_state.back_en = switchback_wdata;
      end

      case (state.mstate)
         mult_off: begin
            if (state.mul_en) begin
               next_state.mstate = mult_warm;
            end
         end
         mult_warm: begin
            if (!state.mul_en) begin
               next_state.mstate = mult_off;
            end else if (warm_done) begin
               next_state.mstate = mult_ready;
            end
         end
         mult_ready: begin
            if (!state.mul_en) begin
               next_state.mstate = mult_off;
            end
         end
         default: next_state.mstate = mult_off;
      endcase

      if (divide_wr) begin
         if (divide_wdata == `CDS_MULT) begin
            if (state.mstate == mult_ready && state.mul_en) begin
               next_state.pend = 1'b1;
               next_state.pend_cds = `CDS_MULT;
            end
         end else if (divide_wdata != `CDS_RSVD) begin
            next_state.cds = divide_wdata;
            next_state.pend = 1'b0;
         end
      end else if (state.pend && mc_start && state.mul_en) begin
         next_state.cds = state.pend_cds;
         next_state.pend = 1'b0;
      end

      // Pending multiply request dies with the multiplier
      if (!state.mul_en) begin
         next_state.pend = 1'b0;
      end

      // Losing the multiplier drops multiply mode back to divide by 1
      if (state.cds == `CDS_MULT && !state.mul_en) begin
         next_state.cds = `CDS_DIV1;
      end

      if (state.cds == `CDS_DIV1024 && state.back_en && (ext_irq_event || rx_start)) begin
         next_state.cds = `CDS_DIV1;
         next_state.pend = 1'b0;
      end

      next_state.sys_en = 1'b0;
      next_state.toggle2x = state.toggle2x;
      case (state.cds)
         `CDS_MULT: begin
            if (state.factor) begin
               next_state.sys_en = 1'b1;
            end else begin
               next_state.toggle2x = !state.toggle2x;
               next_state.sys_en = state.toggle2x;
            end
         end
         `CDS_DIV1024: begin
            if (osc_tick) begin
               if (state.slow_div == 10'(SLOW_COUNT - 1)) begin
                  next_state.slow_div = 10'h000;
                  next_state.sys_en = 1'b1;
               end else begin
                  next_state.slow_div = state.slow_div + 10'h001;
               end
            end
         end
         default: begin
            next_state.sys_en = osc_tick;
            next_state.slow_div = 10'h000;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= '0;
         state.cds <= `CDS_RESET;
         state.rx_s1 <= 1'b1;
         state.rx_s2 <= 1'b1;
         state.rx_prev <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign clock_divide_select = state.cds;
   assign multiplier_enable = state.mul_en;
   assign multiply_factor_select = state.factor;
   assign auto_switchback_enable = state.back_en;
   assign multiplier_ready_flag = (state.mstate == mult_ready) && state.mul_en;
   assign sys_clk_en = state.sys_en;
   assign memcyc_start = mc_start;
endmodule

/* File: tb/clk_div_checker.sv */
/*
 Assertions on the ports of the system clock divide control.
 Assumes a bind to the top module, which hands on its warm-up count.
*/
`timescale 1ns/100ps
module clk_div_checker
   import clk_div_pkg::*;
#(
   parameter int WARMUP_CYCLES = 16
) (
   input wire logic clk_sys, // Clock
   input wire logic rst, // Reset
   input wire logic divide_wr, // Strobe
   input wire logic [1:0] divide_wdata, // Data
   input wire logic enable_wr, // Strobe
   input wire logic factor_wr, // Strobe
   input wire logic ring_osc_mode_flag, // Ring flag
   input wire logic ext_irq_event, // Interrupt
   input wire logic ext_code, // External code
   input wire logic [1:0] clock_divide_select, // Select
   input wire logic multiplier_enable, // Enable
   input wire logic multiply_factor_select, // Factor
   input wire logic auto_switchback_enable, // Switchback
   input wire logic multiplier_ready_flag, // Ready
   input wire logic sys_clk_en, // Tick
   input wire logic memcyc_start // Cycle start
);
   // ----------------------------------------
   // Warm-up length counter
   // ----------------------------------------
   logic [15:0] warm_cnt;
   always_ff @(posedge clk_sys) begin
      if (rst || !multiplier_enable) begin
         warm_cnt <= 16'h0;
      end else if (!multiplier_ready_flag) begin
         warm_cnt <= warm_cnt + 16'h1;
      end
   end
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   reset_state_a: assert property ($fell(rst) |-> clock_divide_select == 2'h2
      && !multiplier_enable && !multiplier_ready_flag) else $error("bad reset state");
   factor_gate_a: assert property (factor_wr && (clock_divide_select != 2'h2
      || multiplier_enable) |=> $stable(multiply_factor_select)) else $error("factor");
   enable_gate_a: assert property (enable_wr && (clock_divide_select != 2'h2
      || ring_osc_mode_flag) |=> $stable(multiplier_enable)) else $error("enable");
   mult_block_a: assert property (divide_wr && divide_wdata == 2'h0
      && !multiplier_ready_flag |=> clock_divide_select != 2'h0) else $error("blocked");
   warm_len_a: assert property ($rose(multiplier_ready_flag) |->
      warm_cnt >= 16'(4 * WARMUP_CYCLES - 8)) else $error("warm-up short");
   warm_bound_a: assert property (warm_cnt <= 16'(4 * WARMUP_CYCLES + 8))
      else $error("ready late");
   mult_take_a: assert property (divide_wr && divide_wdata == 2'h0
      && multiplier_ready_flag && clock_divide_select == 2'h2
      |-> ##[1:24] clock_divide_select == 2'h0) else $error("multiply late");
   switch_back_a: assert property (clock_divide_select == 2'h3
      && auto_switchback_enable && ext_irq_event && !divide_wr
      |=> clock_divide_select == 2'h2) else $error("no switchback");
   mult_keep_a: assert property (clock_divide_select == 2'h0 && ext_irq_event
      && !divide_wr && !enable_wr |=> clock_divide_select == 2'h0) else $error("kept");
   ready_clear_a: assert property ($fell(multiplier_enable) |->
      (!multiplier_ready_flag)[*3]) else $error("ready stuck");
   rate_four_a: assert property (clock_divide_select == 2'h0
      && $past(clock_divide_select, 2) == 2'h0 && multiply_factor_select
      |-> sys_clk_en) else $error("4X rate");
   rate_two_a: assert property (clock_divide_select == 2'h0
      && !multiply_factor_select && sys_clk_en |=> !sys_clk_en) else $error("2X rate");
   int_cycle_a: assert property (!ext_code && sys_clk_en |-> memcyc_start)
      else $error("internal cycle");
   start_tick_a: assert property (memcyc_start |-> sys_clk_en)
      else $error("cycle start off tick");
endmodule
bind system_clock_divide_control clk_div_checker #(.WARMUP_CYCLES(WARMUP_CYCLES)) chk_u (.*);

/* File: tb/system_clock_divide_control_test.sv */
/*
 Testbench of the system clock divide control.
 Assumes short counts: warm-up 16 oscillator cycles, slow count 4.
*/
`timescale 1ns/100ps
module system_clock_divide_control_test;
   import clk_div_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, ring_osc_mode_flag = 1'b0;
   logic divide_wr = 1'b0, enable_wr = 1'b0, factor_wr = 1'b0, switchback_wr = 1'b0;
   logic [1:0] divide_wdata = 2'h0;
   logic enable_wdata = 1'b0, factor_wdata = 1'b0, switchback_wdata = 1'b0;
   logic ext_irq_event = 1'b0, serial_start_pin = 1'b1, ext_code = 1'b0;
   ext_bus_t bus_mode = bus_one;
   logic [1:0] clock_divide_select;
   logic multiplier_enable, multiply_factor_select, auto_switchback_enable;
   logic multiplier_ready_flag, sys_clk_en, memcyc_start;
   int errors = 0, check_count = 0, n;
   system_clock_divide_control #(.WARMUP_CYCLES(16), .SLOW_COUNT(4)) dut_u (.*);
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // Access and compare tasks
   // ----------------------------------------
   task automatic close_out();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input int k, input logic [1:0] d);
      @(negedge clk_sys);
      divide_wdata = d;
      enable_wdata = d[0];
      factor_wdata = d[0];
      switchback_wdata = d[0];
      {switchback_wr, factor_wr, enable_wr, divide_wr} = 4'(1 << k);
      @(negedge clk_sys);
      {switchback_wr, factor_wr, enable_wr, divide_wr} = 4'h0;
   endtask
   task automatic pulse_irq();
      ext_irq_event = 1'b1;
      @(negedge clk_sys);
      ext_irq_event = 1'b0;
   endtask
   task automatic wait_sel(input logic [1:0] e, input int lim);
      int c;
      c = 0;
      while (clock_divide_select !== e) begin
         @(negedge clk_sys);
         c++;
         if (c > lim) begin
            errors++;
            $display("[FAIL] %0t select wait timed out", $time);
            close_out();
         end
      end
   endtask
   // Clocks between two system ticks
   task automatic gap(input int g);
      int c;
      c = 0;
      while (sys_clk_en !== 1'b1 && c < 5000) begin
         @(negedge clk_sys);
         c++;
      end
      c = 0;
      do begin
         @(negedge clk_sys);
         c++;
      end while (sys_clk_en !== 1'b1 && c < 5000);
      chk(16'(c), 16'(g));
   endtask
   task automatic engage(input logic f, input int g);
      int c;
      wr(2, {1'b0, f});
      chk(16'(multiply_factor_select), 16'(f));
      wr(1, 2'h1);
      chk(16'(multiplier_enable), 16'h1);
      wr(2, {1'b0, !f});
      chk(16'(multiply_factor_select), 16'(f));
      wr(0, 2'h0);
      chk(16'({clock_divide_select, multiplier_ready_flag}), 16'h4);
      c = 4;
      while (multiplier_ready_flag !== 1'b1 && c < 200) begin
         @(negedge clk_sys);
         c++;
      end
      chk(16'(c >= 56 && c <= 80), 16'h1);
      wr(0, 2'h0);
      wait_sel(2'h0, 24);
      gap(g);
      pulse_irq();
      chk(16'(clock_divide_select), 16'h0);
      wr(1, 2'h0);
      chk(16'(multiplier_enable), 16'h1);
      wr(0, 2'h2);
      wr(1, 2'h0);
      chk(16'({clock_divide_select, multiplier_ready_flag}), 16'h4);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      chk(16'({clock_divide_select, multiplier_enable, multiply_factor_select,
         auto_switchback_enable, multiplier_ready_flag}), 16'h20);
      gap(4);
      ring_osc_mode_flag = 1'b1;
      wr(1, 2'h1);
      chk(16'(multiplier_enable), 16'h0);
      ring_osc_mode_flag = 1'b0;
      engage(1'b1, 1);
      engage(1'b0, 2);
      wr(3, 2'h1);
      wr(0, 2'h3);
      gap(16);
      pulse_irq();
      chk(16'(clock_divide_select), 16'h2);
      wr(0, 2'h3);
      serial_start_pin = 1'b0;
      wait_sel(2'h2, 8);
      serial_start_pin = 1'b1;
      wr(3, 2'h0);
      wr(0, 2'h3);
      pulse_irq();
      chk(16'(clock_divide_select), 16'h3);
      wr(0, 2'h2);
      for (int i = 0; i < 4; i++) begin
         ext_code = (i != 0);
         bus_mode = ext_bus_t'((i == 0) ? 0 : i - 1);
         repeat (16) @(negedge clk_sys);
         n = 0;
         repeat (64) begin
            @(negedge clk_sys);
            n += int'(memcyc_start === 1'b1);
         end
         chk(16'(n), 16'(16 >> ((i == 0) ? 0 : i - 1)));
      end
      close_out();
   end
endmodule
